// ### common/shls_defs.svh
// Constants of the handler sorting and control port block
// Assumes a 25 MHz core clock
`ifndef SHLS_DEFS_SVH
`define SHLS_DEFS_SVH
`define SHLS_CLK_MHZ        25
`define SHLS_TRIG_MIN_US    1
`define SHLS_START_MIN_US   200
`define SHLS_START_CYC      (`SHLS_START_MIN_US * `SHLS_CLK_MHZ)
`define SHLS_TRIG_CYC       (`SHLS_TRIG_MIN_US * `SHLS_CLK_MHZ)
`define SHLS_RETRIG_WAIT_US 0
`define SHLS_GRADE_W        4
`define SHLS_LINES_RST      16'hffff
`endif

// ### common/shls_pkg.sv
// Types of the handler sorting and control port block
// Assumes nothing beyond the defs header
package shls_pkg;
  typedef enum logic [1:0] {
    SHLS_MODE_POINT = 2'h0,
    SHLS_MODE_LIST  = 2'h1,
    SHLS_MODE_SWEEP = 2'h2
  } shls_mode_t;
  typedef enum logic [3:0] {
    SHLS_IDLE  = 4'h1,
    SHLS_WAIT  = 4'h2,
    SHLS_MEAS  = 4'h4,
    SHLS_DONE  = 4'h8
  } shls_state_t;
endpackage

// ### verification/shls_handler_model.sv
// Handler model: drives the external start pin low as one held pulse
// Assumes the bench asks for a trigger with a one-cycle go strobe
`timescale 1ns/1ps
`default_nettype none
module shls_handler_model (
  input  wire logic core_clk,
  input  wire logic go,
  output logic      external_start_input_n
);
  int hold_ff = 0;
  // ------------------------------------------------------------
  // Pulse of 30 cycles, above the 1 us minimum width
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (go) hold_ff <= 30;
    else if (hold_ff > 0) hold_ff <= hold_ff - 1;
  end
  assign external_start_input_n = (hold_ff == 0);
endmodule
`default_nettype wire

// ### verification/test_sorter_handler_list_sweep.sv
// Bench: triggers scans in every mode and compares the sorting lines
// Assumes the handler model above and a 25 MHz core clock
`timescale 1ns/1ps
`include "shls_defs.svh"
`default_nettype none
module test_sorter_handler_list_sweep;
  logic        core_clk = 0, rst_n = 0, go = 0, keylock_in_n = 1, power_fail = 0;
  logic        ext_sel = 1;
  int          starts = 0, base = 0;
  logic        analog_last_done = 0, result_valid = 0, result_invalid = 0;
  logic [1:0]  meas_mode = 2'h1;
  logic [3:0]  result_grade = 4'h0, curve_pass = 4'h0, curve_fail = 4'h0;
  logic [15:0] lines_n;
  logic [31:0] seed = 32'h5;
  logic        meas_start_ff, keylock_ff, adone_n, mdone_n, ploss_n;
  wire         ext_n;
  int          fail_count = 0, samples_checked = 0, cycles = 0;
  always #20 core_clk = ~core_clk;
  shls_handler_model i_shls_handler_model (.core_clk(core_clk), .go(go),
    .external_start_input_n(ext_n));
  shls_handler i_shls_handler (.core_clk(core_clk), .rst_n(rst_n), .meas_mode(meas_mode),
    .external_start_input_sel(ext_sel), .external_start_input_n(ext_n), .keylock_in_n(keylock_in_n),
    .power_fail(power_fail), .analog_last_done(analog_last_done),
    .result_valid(result_valid), .result_grade(result_grade),
    .result_invalid(result_invalid), .curve_pass(curve_pass), .curve_fail(curve_fail),
    .meas_start_ff(meas_start_ff), .keylock_ff(keylock_ff),
    .grade_lines_one_to_nine_n_ff(lines_n[8:0]), .grade_ten_flag_n_ff(lines_n[9]),
    .grade_eleven_flag_n_ff(lines_n[10]), .grade_twelve_flag_n_ff(lines_n[11]),
    .grade_thirteen_flag_n_ff(lines_n[12]), .grade_fourteen_flag_n_ff(lines_n[13]),
    .grade_fifteen_flag_n_ff(lines_n[14]), .invalid_result_flag_n_ff(lines_n[15]),
    .analog_done_n_ff(adone_n), .measurement_done_flag_n_ff(mdone_n),
    .power_loss_n_ff(ploss_n));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // One triggered scan with a random result
  // ------------------------------------------------------------
  task automatic meas(input logic [1:0] m);
    logic [15:0] e;
    logic [3:0]  g, p, f;
    logic        inv;
    int          n;
    g = 4'(rnd() % 15 + 1);
    p = 4'(rnd());
    f = 4'(rnd());
    inv = 1'(rnd());
    @(posedge core_clk);
    meas_mode <= m;
    go <= 1'b1;
    @(posedge core_clk) go <= 1'b0;
    n = 0;
    while (meas_start_ff !== 1'b1 && n < 6000) begin
      @(posedge core_clk) go <= (n == 100);
      #1 n++;
    end
    chk("start_delay", 16'(n >= `SHLS_START_CYC && n <= `SHLS_START_CYC + 10), 16'h1);
    @(posedge core_clk) #1;
    chk("cleared", {lines_n[15:0]}, 16'hffff);
    chk("flags_cleared", {14'h0, adone_n, mdone_n}, 16'h3);
    @(posedge core_clk);
    result_grade <= g;
    result_invalid <= inv;
    curve_pass <= p;
    curve_fail <= f;
    analog_last_done <= 1'b1;
    @(posedge core_clk) analog_last_done <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk("analog_done", {14'h0, adone_n, mdone_n}, 16'h1);
    chk("no_early_lines", lines_n, 16'hffff);
    @(posedge core_clk) result_valid <= 1'b1;
    @(posedge core_clk) result_valid <= 1'b0;
    #1;
    e = 16'hffff;
    if (m == 2'h2) begin
      e[7:0] = {~f, ~p};
    end else begin
      e[g - 1] = 1'b0;
    end
    e[15] = ~inv;
    chk("done", 16'(mdone_n), 16'h0);
    chk("lines", lines_n, e);
    repeat (20) @(posedge core_clk);
    #1 chk("lines_hold", lines_n, e);
  endtask
  always @(posedge core_clk) begin
    if (meas_start_ff === 1'b1) starts++;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk("reset_idle", {lines_n[12:0], adone_n, mdone_n, ploss_n}, 16'hffff);
    for (int i = 0; i < 6; i++) meas(2'(i % 3));
    @(posedge core_clk);
    ext_sel <= 1'b0;
    go <= 1'b1;
    base = starts;
    @(posedge core_clk) go <= 1'b0;
    repeat (5100) @(posedge core_clk);
    #1 chk("no_start", 16'(starts - base), 16'h0);
    @(posedge core_clk);
    keylock_in_n <= 1'b0;
    power_fail <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1 chk("keylock_power", {14'h0, keylock_ff, ploss_n}, 16'h2);
    end_sim();
  end
endmodule
`default_nettype wire

// ### verilog/shls_handler.sv
// Handler port logic: grade line mapping, done flags, power loss, trigger
// Assumes measurement core pulses on the same clock; pins are asynchronous
//
// Function
// - Line meaning is chosen by the measurement mode: point and list share the grade mapping, sweep has its own.
// - List grades 1-9 go to lines one to nine, 10-15 to six extra lines, plus an invalid flag.
// - In list mode the sorting lines are cleared at the start and set only after the whole list finishes.
// - In list and sweep modes analog-done asserts when the last point's analog part ends.
// - Measurement-done asserts only after the scan ends with all lines valid.
// - In sweep mode lines one to four show pass of curves one to four.
// - In sweep mode lines five to eight show fail of curves one to four.
// - The power-loss output asserts whenever power is lost, in every mode.
// - The external start and keylock inputs are taken from the handler.
// - List handshake timing uses the same limits as point measurement.
// - With external trigger selected a falling edge of the active-low start input starts measuring.
// - Measuring starts no earlier than the minimum delay after the trigger edge.
`timescale 1ns/1ps
`include "shls_defs.svh"
`default_nettype none
module shls_handler (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  meas_mode,
  input  wire logic        external_start_input_sel,
  input  wire logic        external_start_input_n,
  input  wire logic        keylock_in_n,
  input  wire logic        power_fail,
  input  wire logic        analog_last_done,
  input  wire logic        result_valid,
  input  wire logic [3:0]  result_grade,
  input  wire logic        result_invalid,
  input  wire logic [3:0]  curve_pass,
  input  wire logic [3:0]  curve_fail,
  output logic             meas_start_ff,
  output logic             keylock_ff,
  output logic [8:0]       grade_lines_one_to_nine_n_ff,
  output logic             grade_ten_flag_n_ff,
  output logic             grade_eleven_flag_n_ff,
  output logic             grade_twelve_flag_n_ff,
  output logic             grade_thirteen_flag_n_ff,
  output logic             grade_fourteen_flag_n_ff,
  output logic             grade_fifteen_flag_n_ff,
  output logic             invalid_result_flag_n_ff,
  output logic             analog_done_n_ff,
  output logic             measurement_done_flag_n_ff,
  output logic             power_loss_n_ff
);
  localparam logic [13:0] START_CYC = 14'(`SHLS_START_CYC);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [1:0] trig_sync_ff;
  logic [1:0] key_sync_ff;
  logic [1:0] pwr_sync_ff;
  logic       trig_prev_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync_ff <= 2'h0;
      key_sync_ff  <= 2'h0;
      pwr_sync_ff  <= 2'h0;
      trig_prev_ff <= 1'b0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[0], ~external_start_input_n};
      key_sync_ff  <= {key_sync_ff[0], ~keylock_in_n};
      pwr_sync_ff  <= {pwr_sync_ff[0], power_fail};
      trig_prev_ff <= trig_sync_ff[1];
    end
  end
  wire trig_rise = trig_sync_ff[1] & ~trig_prev_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      keylock_ff      <= 1'b0;
      power_loss_n_ff <= 1'b1;
    end else begin
      keylock_ff      <= key_sync_ff[1];
      power_loss_n_ff <= ~pwr_sync_ff[1];
    end
  end

  // ------------------------------------------------------------------
  // Trigger sequencer
  // ------------------------------------------------------------------
  shls_pkg::shls_state_t state_ff;
  logic [13:0]           dly_ff;
  logic                  ext_mode;
  assign ext_mode = external_start_input_sel;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= shls_pkg::SHLS_IDLE;
      dly_ff        <= 14'h0;
      meas_start_ff <= 1'b0;
    end else begin
      meas_start_ff <= 1'b0;
      unique case (state_ff)
        shls_pkg::SHLS_IDLE, shls_pkg::SHLS_DONE: begin
          if (ext_mode && trig_rise) begin
            state_ff <= shls_pkg::SHLS_WAIT;
            dly_ff   <= 14'h0;
          end
        end
        shls_pkg::SHLS_WAIT: begin
          if (dly_ff == START_CYC - 14'h1) begin
            state_ff      <= shls_pkg::SHLS_MEAS;
            meas_start_ff <= 1'b1;
          end else begin
            dly_ff <= dly_ff + 14'h1;
          end
        end
        shls_pkg::SHLS_MEAS: begin
          if (result_valid) begin
            state_ff <= shls_pkg::SHLS_DONE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Sorting lines and done flags
  // ------------------------------------------------------------------
  logic [15:0] dec;
  assign dec = 16'h1 << result_grade;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      grade_lines_one_to_nine_n_ff <= 9'h1ff;
      grade_ten_flag_n_ff          <= 1'b1;
      grade_eleven_flag_n_ff       <= 1'b1;
      grade_twelve_flag_n_ff       <= 1'b1;
      grade_thirteen_flag_n_ff     <= 1'b1;
      grade_fourteen_flag_n_ff     <= 1'b1;
      grade_fifteen_flag_n_ff      <= 1'b1;
      invalid_result_flag_n_ff     <= 1'b1;
      analog_done_n_ff             <= 1'b1;
      measurement_done_flag_n_ff   <= 1'b1;
    end else begin
      if (meas_start_ff) begin
        grade_lines_one_to_nine_n_ff <= 9'h1ff;
        grade_ten_flag_n_ff          <= 1'b1;
        grade_eleven_flag_n_ff       <= 1'b1;
        grade_twelve_flag_n_ff       <= 1'b1;
        grade_thirteen_flag_n_ff     <= 1'b1;
        grade_fourteen_flag_n_ff     <= 1'b1;
        grade_fifteen_flag_n_ff      <= 1'b1;
        invalid_result_flag_n_ff     <= 1'b1;
        analog_done_n_ff             <= 1'b1;
        measurement_done_flag_n_ff   <= 1'b1;
      end
      // A result in the start cycle wins over the clear
      if (state_ff == shls_pkg::SHLS_MEAS) begin
        if (analog_last_done) begin
          analog_done_n_ff <= 1'b0;
        end
        if (result_valid) begin
          invalid_result_flag_n_ff   <= ~result_invalid;
          measurement_done_flag_n_ff <= 1'b0;
          unique case (meas_mode)
            2'(shls_pkg::SHLS_MODE_SWEEP): begin
              grade_lines_one_to_nine_n_ff <= {1'b1, ~curve_fail, ~curve_pass};
            end
            default: begin
              grade_lines_one_to_nine_n_ff <= ~dec[9:1];
              grade_ten_flag_n_ff          <= ~dec[10];
              grade_eleven_flag_n_ff       <= ~dec[11];
              grade_twelve_flag_n_ff       <= ~dec[12];
              grade_thirteen_flag_n_ff     <= ~dec[13];
              grade_fourteen_flag_n_ff     <= ~dec[14];
              grade_fifteen_flag_n_ff      <= ~dec[15];
            end
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Cycles since the last accepted trigger, for the start delay check
  logic [13:0] gap_cnt_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_ff <= 14'h0;
    end else if ((state_ff == shls_pkg::SHLS_IDLE || state_ff == shls_pkg::SHLS_DONE) &&
                 ext_mode && trig_rise) begin
      gap_cnt_ff <= 14'h0;
    end else if (gap_cnt_ff != 14'h3fff) begin
      gap_cnt_ff <= gap_cnt_ff + 14'h1;
    end
  end
  property p_start_delay;
    @(posedge core_clk) disable iff (!rst_n)
      meas_start_ff |-> gap_cnt_ff >= START_CYC;
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("Start came too early");
  property p_clear;
    @(posedge core_clk) disable iff (!rst_n)
      (meas_start_ff && !analog_last_done && !result_valid) |=>
      measurement_done_flag_n_ff && analog_done_n_ff;
  endproperty
  a_clear: assert property (p_clear) else $error("Done flags not cleared");
  property p_done;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(measurement_done_flag_n_ff) |-> $past(result_valid);
  endproperty
  a_done: assert property (p_done) else $error("Done without valid result");
  property p_sweep;
    @(posedge core_clk) disable iff (!rst_n)
      (state_ff == shls_pkg::SHLS_MEAS && result_valid && !meas_start_ff &&
       meas_mode == 2'(shls_pkg::SHLS_MODE_SWEEP)) |=>
      grade_lines_one_to_nine_n_ff[7:0] == ~{$past(curve_fail), $past(curve_pass)};
  endproperty
  a_sweep: assert property (p_sweep) else $error("Sweep lines wrong");
  property p_pwr;
    @(posedge core_clk) disable iff (!rst_n)
      pwr_sync_ff[1] |=> !power_loss_n_ff;
  endproperty
  a_pwr: assert property (p_pwr) else $error("Power loss not shown");
  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (state_ff == shls_pkg::SHLS_DONE && !meas_start_ff) |=>
      $stable(grade_lines_one_to_nine_n_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("Lines changed while held");
endmodule
`default_nettype wire
